// [common/burst_sram_pkg.sv]
// constants and types shared by the pipelined burst sram port
package burst_sram_pkg;
    localparam int ADDR_W_DEF  = 18;
    localparam int LANES_DEF   = 4;
    localparam int LANE_W_DEF  = 9;
    localparam int BURST_W     = 2;
    localparam logic [1:0] BEAT_RESET = 2'h0;

    typedef enum logic [2:0] {
        OP_IDLE  = 3'b001,
        OP_READ  = 3'b010,
        OP_WRITE = 3'b100
    } op_t;
endpackage

// [logic/burst_order_gen.sv]
// burst address sequencer for the low two address bits
`timescale 1ns/1ps
`default_nettype none
module burst_order_gen
    import burst_sram_pkg::*;
(
    input  wire logic [BURST_W-1:0] start_ofs,
    input  wire logic [BURST_W-1:0] beat,
    input  wire logic               interleave,
    output logic      [BURST_W-1:0] ofs
);
    always_comb begin
        if (interleave) begin
            ofs = start_ofs ^ beat;
        end else begin
            ofs = BURST_W'(start_ofs + beat);
        end
    end
endmodule // burst_order_gen
`default_nettype wire

// [logic/burst_sram_port.sv]
// pipelined burst sram access port with byte writes and shared data bus
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port
    import burst_sram_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int LANES  = LANES_DEF,
    parameter int LANE_W = LANE_W_DEF
) (
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    input  wire logic                     clk_qualify_n,
    input  wire logic                     chip_sel1_n,
    input  wire logic                     chip_sel2,
    input  wire logic                     chip_sel3_n,
    input  wire logic                     advance_or_load,
    input  wire logic                     write_n,
    input  wire logic [LANES-1:0]         byte_lane_sel_n,
    input  wire logic [ADDR_W-1:0]        addr,
    input  wire logic                     burst_order,
    input  wire logic                     out_enable_n,
    input  wire logic [LANES*LANE_W-1:0]  data_in,
    output logic      [LANES*LANE_W-1:0]  data_out,
    output logic      [LANES*LANE_W-1:0]  data_oe
);
    localparam int DW    = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    logic [DW-1:0] mem [DEPTH];

    // command stage: address/beat of the access taken at the last edge
    op_t                 op_r,       op_nxt;
    logic [ADDR_W-1:0]   base_r,     base_nxt;
    logic [BURST_W-1:0]  beat_r,     beat_nxt;
    logic                burst_wr_r, burst_wr_nxt;
    logic                order_r,    order_nxt;
    // lane selects of the command taken at the last edge
    logic [LANES-1:0]    wlane_r,    wlane_nxt;
    // output stage
    logic [DW-1:0]       dout_r,     dout_nxt;
    logic [DW-1:0]       oe_r,       oe_nxt;

    logic [BURST_W-1:0]  ofs_cur;
    logic [ADDR_W-1:0]   acc_addr;
    logic                all_sel;
    logic                run;

    function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] sel_n);
        logic [DW-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{~sel_n[i]}};
        end
        return m;
    endfunction

    burst_order_gen u_order (
        .start_ofs  (base_r[BURST_W-1:0]),
        .beat       (beat_r),
        .interleave (order_r),
        .ofs        (ofs_cur)
    );

    assign run      = ~clk_qualify_n;
    assign all_sel  = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
    assign acc_addr = {base_r[ADDR_W-1:BURST_W], ofs_cur};

    always_comb begin
        op_nxt       = op_r;
        base_nxt     = base_r;
        beat_nxt     = beat_r;
        burst_wr_nxt = burst_wr_r;
        order_nxt    = order_r;
        if (run) begin
            if (!advance_or_load) begin
                base_nxt  = addr;
                beat_nxt  = BEAT_RESET;
                // order held per burst: a pin change mid-burst cannot skew beats
                order_nxt = burst_order;
                if (!all_sel) begin
                    op_nxt = OP_IDLE;
                end else if (write_n) begin
                    op_nxt       = OP_READ;
                    burst_wr_nxt = 1'b0;
                end else begin
                    op_nxt       = OP_WRITE;
                    burst_wr_nxt = 1'b1;
                end
            end else begin
                // advance keeps the latched access type, selects ignored
                beat_nxt = BURST_W'(beat_r + 1'b1);
                if (op_r != OP_IDLE) begin
                    op_nxt = burst_wr_r ? OP_WRITE : OP_READ;
                end
            end
        end
    end

    always_comb begin
        wlane_nxt = wlane_r;
        if (run) begin
            // byte selects are sampled with each beat's command
            wlane_nxt = byte_lane_sel_n;
        end
    end

    // write address must follow the command of the previous edge
    logic [ADDR_W-1:0] cmd_waddr_r, cmd_waddr_nxt;
    logic [LANES-1:0]  cmd_lane_r,  cmd_lane_nxt;
    logic              cmd_wr_r,    cmd_wr_nxt;

    always_comb begin
        cmd_waddr_nxt = cmd_waddr_r;
        cmd_lane_nxt  = cmd_lane_r;
        cmd_wr_nxt    = cmd_wr_r;
        if (run) begin
            cmd_wr_nxt    = (op_r == OP_WRITE);
            cmd_waddr_nxt = acc_addr;
            cmd_lane_nxt  = wlane_r;
        end
    end

    always_comb begin
        dout_nxt = dout_r;
        oe_nxt   = oe_r;
        if (run) begin
            if (op_r == OP_READ) begin
                dout_nxt = mem[acc_addr];
            end
            // output enable counts only on qualified edges, so a suspend freezes the pins
            if (op_r == OP_READ && !out_enable_n) begin
                oe_nxt = {DW{1'b1}};
            end else begin
                oe_nxt = '0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            op_r        <= OP_IDLE;
            base_r      <= '0;
            beat_r      <= BEAT_RESET;
            burst_wr_r  <= 1'b0;
            order_r     <= 1'b0;
            wlane_r     <= '1;
            cmd_waddr_r <= '0;
            cmd_lane_r  <= '1;
            cmd_wr_r    <= 1'b0;
            dout_r      <= '0;
            oe_r        <= '0;
        end else begin
            op_r        <= op_nxt;
            base_r      <= base_nxt;
            beat_r      <= beat_nxt;
            burst_wr_r  <= burst_wr_nxt;
            order_r     <= order_nxt;
            wlane_r     <= wlane_nxt;
            cmd_waddr_r <= cmd_waddr_nxt;
            cmd_lane_r  <= cmd_lane_nxt;
            cmd_wr_r    <= cmd_wr_nxt;
            dout_r      <= dout_nxt;
            oe_r        <= oe_nxt;
        end
    end

    // array holds no reset; contents undefined until written
    always_ff @(posedge clk_sys) begin
        if (run && cmd_wr_r) begin
            mem[cmd_waddr_r] <= (mem[cmd_waddr_r] & ~lane_mask(cmd_lane_r))
                              | (data_in & lane_mask(cmd_lane_r));
        end
    end

    assign data_out = dout_r;
    assign data_oe  = oe_r;
endmodule // burst_sram_port
`default_nettype wire

// [bench/burst_sram_port_assertions.sv]
// checker on the burst sram port pins
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port_assertions #(parameter int LANES = 4, parameter int LANE_W = 9) (
    input wire logic                    clk_sys,
    input wire logic                    nrst,
    input wire logic                    clk_qualify_n,
    input wire logic                    chip_sel1_n,
    input wire logic                    chip_sel2,
    input wire logic                    chip_sel3_n,
    input wire logic                    advance_or_load,
    input wire logic                    write_n,
    input wire logic                    out_enable_n,
    input wire logic [LANES*LANE_W-1:0] data_out,
    input wire logic [LANES*LANE_W-1:0] data_oe
);
    wire ld  = !clk_qualify_n && !advance_or_load;
    wire sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
    wire rd  = ld && sel && write_n;
    wire wr  = ld && sel && !write_n;
    wire go  = !clk_qualify_n && !out_enable_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    AST_FREEZE:
    assert property (clk_qualify_n |=> $stable(data_out) && $stable(data_oe)) else $error("held");
    AST_READ:
    assert property (rd ##1 go |=> &data_oe) else $error("read not driven");
    AST_OE_OFF:
    assert property (!clk_qualify_n && out_enable_n |=> data_oe == '0) else $error("oe off");
    AST_WR_FLOAT:
    assert property (wr ##1 !clk_qualify_n |=> data_oe == '0) else $error("write drive");
    AST_DESEL:
    assert property (ld && !sel ##1 !clk_qualify_n |=> data_oe == '0) else $error("deselect");
    AST_PWRUP:
    assert property ($rose(nrst) |-> data_oe == '0) else $error("reset drive");
    AST_OE_CAUSE:
    assert property ($rose(|data_oe) |-> $past(out_enable_n) == 1'b0) else $error("oe cause");
    AST_OUT_REG:
    assert property ($changed(data_out) |-> $past(clk_qualify_n) == 1'b0) else $error("out reg");
    AST_B2B:
    assert property (rd ##1 (rd && go) ##1 go |=> &data_oe) else $error("b2b read");
    cover property (rd ##1 go);
    cover property (wr ##2 !clk_qualify_n);
    cover property (ld && !sel);
endmodule // burst_sram_port_assertions
bind burst_sram_port burst_sram_port_assertions #(.LANES(LANES), .LANE_W(LANE_W))
    burst_sram_port_assertions_inst (.*);
`default_nettype wire

// [bench/sram_ctrl_model.sv]
// controller side of the shared data bus
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_model (
    input  wire logic        clk_sys,
    input  wire logic [35:0] data_out,
    input  wire logic [35:0] data_oe,
    output logic      [35:0] data_in
);
    logic        drv  = 1'b0;
    logic [35:0] wd   = '0;
    logic [35:0] last = '0;
    // floating bus toggles so stale data never matches
    assign data_in = (|data_oe) ? data_out : drv ? wd : ~last;
    always @(posedge clk_sys) last <= data_in;
    task automatic put(input logic en, input logic [35:0] d);
        drv = en;
        wd  = d;
    endtask
endmodule // sram_ctrl_model
`default_nettype wire

// [bench/pipelined_burst_sram_port_bench.sv]
// random bench with a cycle reference of the port
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_port_bench;
    import burst_sram_pkg::*;
    logic        clk_sys = 1'b0, nrst = 1'b0, clk_qualify_n = 1'b0, write_n = 1'b0;
    logic        chip_sel1_n = 1'b0, chip_sel2 = 1'b1, chip_sel3_n = 1'b0, oe_x = 1'b0;
    logic        advance_or_load = 1'b0, burst_order = 1'b0, out_enable_n = 1'b0;
    logic [3:0]  byte_lane_sel_n = 4'h0, l2, l1;
    logic [5:0]  addr = 6'h0, b1, a1, a2;
    logic [1:0]  bt;
    logic [35:0] data_in, data_out, data_oe, dx = '0;
    logic [35:0] mem [64];
    logic [31:0] r;
    op_t         k1 = OP_IDLE, k2 = OP_IDLE;
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    burst_sram_port #(.ADDR_W(6)) burst_sram_port_inst (.*);
    sram_ctrl_model sram_ctrl_model_inst (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    function automatic logic [5:0] eff(logic [5:0] b, logic [1:0] n, logic il);
        return {b[5:2], il ? b[1:0] ^ n : b[1:0] + n};
    endfunction
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end
    always @(posedge clk_sys) begin
        if (nrst && !clk_qualify_n) begin
            // a read leaves before a write landing at the same edge
            if (k1 == OP_READ) dx = mem[a1];
            if (k2 == OP_WRITE)
                for (int i = 0; i < 4; i++)
                    if (!l2[i]) mem[a2][i*9+:9] = data_in[i*9+:9];
            k2 = k1 == OP_WRITE ? OP_WRITE : OP_IDLE;
            {a2, l2} = {a1, l1};
            oe_x = k1 == OP_READ && !out_enable_n;
            if (!advance_or_load) begin
                k1 = (chip_sel1_n || !chip_sel2 || chip_sel3_n) ? OP_IDLE
                   : write_n ? OP_READ : OP_WRITE;
                {b1, bt} = {addr, 2'h0};
            end else if (k1 != OP_IDLE) bt++;
            a1 = eff(b1, bt, burst_order);
            l1 = byte_lane_sel_n;
        end
    end
    always @(negedge clk_sys) begin
        chk(data_oe, {36{oe_x}});
        if (oe_x) chk(data_out, dx);
        sram_ctrl_model_inst.put(k2 == OP_WRITE, {4'($urandom()), $urandom()});
    end
    initial begin
        void'($urandom(444));
        repeat (8) @(negedge clk_sys);
        nrst = 1'b1;
        // fill every word with linear write bursts first
        for (int i = 0; i < 64; i++) begin
            @(negedge clk_sys);
            advance_or_load = i % 4 != 0;
            addr = i[5:0];
        end
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk_sys);
            r = $urandom();
            clk_qualify_n = r[2:0] == 3'h0;
            {chip_sel1_n, chip_sel2, chip_sel3_n} = {r[5:3] == 3'h1, r[5:3] != 3'h2, r[5:3] == 3'h3};
            {write_n, out_enable_n, byte_lane_sel_n} = {r[6], r[9:7] == 3'h0, r[13:10]};
            advance_or_load = r[15:14] != 2'h0 && k1 != OP_IDLE;
            addr = r[21:16];
            if (!advance_or_load && !clk_qualify_n) burst_order = r[22];
        end
        repeat (4) @(negedge clk_sys);
        test_done();
    end
endmodule // pipelined_burst_sram_port_bench
`default_nettype wire
